//--- design/tfic_top.sv
// Timer control, status, flag clearing and APB register access
// Notes on behaviour
// [R1] Compare pin is low after reset until a match clocks a set level out.
// [R2] Control bit 7 enables capture request, asserting with capture flag.
// [R3] Control bit 6 enables compare request, asserting with compare flag.
// [R4] Control bit 5 enables rollover request, asserting with rollover flag.
// [R5] Control bit 1 picks capture edge: 0 falling, 1 rising.
// [R6] Control bit 0 is the level driven out at the next compare match.
// [R7] Flags clear only after status read then access of the flag's register; the capture flag also clears on a reset-pin stop exit.
// [R8] Alternate counter reads same value and never clears the rollover flag.
// [R9] Capture flag sets on selected edge, clears by status then capture-low read.
// [R10] Compare flag sets on equality, clears by status then compare-low write.
// [R11] Rollover flag sets at FFFF to 0000, clears by status then counter-low read.
// [R12] Wait and halt leave the timer running; enabled requests wake the core.
// [R13] Stop freezes the counter; interrupt-pin exit resumes from frozen value.
// [R14] Stop exit by reset pin forces the counter to FFFC.
// [R15] Edge in stop only arms capture; flag and data appear on wake.
// [R16] Reset-pin stop exit discards any armed capture.
// [R17] Counter advances once every four clocks through a fixed prescaler.
// [R18] Capture-high read blocks captures until capture-low is read.
// [R19] Compare-high write suspends matching until compare-low is written.
// [R20] Counter-high read latches low byte until the low byte read.
// [R21] One interrupt request while any flag and its enable are both set.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tfic_defs.svh"
module tfic_top
    import tfic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_in_pin,
    output logic             compare_out_pin,
    input  wire logic        stop_mode,
    input  wire logic        stop_exit_reset,
    output logic             timer_irq
);
    tfic_ev_if   ev ();
    logic        tick;
    logic        roll;
    tfic_count_t count;
    logic [7:0]  control_q;
    logic        cap_f_q, cmp_f_q, roll_f_q;
    logic        arm_cap_q, arm_cmp_q, arm_roll_q;
    tfic_count_t cap_q, cmp_q;
    logic        cap_block_q, cmp_block_q, cnt_hold_q, alt_hold_q;
    logic [7:0]  cnt_buf_q, alt_buf_q;
    logic        pin_q;
    logic        pend_q;
    tfic_count_t pend_val_q;
    logic        out_q, irq_q;
    logic [2:0]  clr_arm_q;
    logic [7:0]  ctl_nx;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic        setup, wr, rd, edge_hit, cap_ev, cmp_ev;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    tfic_counter #(
        .PRESCALE        (`TFIC_PRESCALE)
    ) u_counter (
        .pclk            (pclk),
        .presetn         (presetn),
        .stop_mode       (stop_mode),
        .stop_exit_reset (stop_exit_reset),
        .tick            (tick),
        .count           (count),
        .roll            (roll)
    );

    // ----------------------------------------------------------------
    // APB strobes: one access per setup cycle, answered next cycle
    // ----------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr    = setup && pwrite;
    assign rd    = setup && !pwrite;

    // ----------------------------------------------------------------
    // Capture edge detection and stop-mode arming
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= capture_in_pin;
        end
    end

    assign edge_hit = control_q[`TFIC_BIT_EDGE_SEL] ? (capture_in_pin && !pin_q)
                                                     : (!capture_in_pin && pin_q); // [R5]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q     <= 1'b0;
            pend_val_q <= 16'h0000;
        end else if (stop_exit_reset) begin
            pend_q     <= 1'b0; // [R16]
        end else if (stop_mode && edge_hit && !pend_q) begin
            pend_q     <= 1'b1; // [R15]
            pend_val_q <= count + 16'h0001;
        end else if (!stop_mode) begin
            pend_q     <= 1'b0;
        end
    end

    assign cap_ev = !stop_mode && !stop_exit_reset && !cap_block_q && (edge_hit || pend_q); // [R15] [R18]
    assign cmp_ev = tick && !cmp_block_q && cmp_q == count; // [R10] [R19]

    assign ev.cap_ev   = cap_ev;
    assign ev.cmp_ev   = cmp_ev;
    assign ev.roll_ev  = roll;
    assign ev.drop_cap = stop_exit_reset;
    assign ev.count    = count;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= `TFIC_CONTROL_RESET; // [R1]
        end else if (wr && hit(paddr, `TFIC_OFS_CONTROL)) begin
            control_q <= pwdata[7:0] & 8'he3;
        end
    end

    // ----------------------------------------------------------------
    // Capture and compare data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= `TFIC_CAP_RESET;
        end else if (cap_ev) begin
            cap_q <= (pend_q && !edge_hit) ? pend_val_q : count + 16'h0001; // [R15] [R18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= `TFIC_CMP_RESET;
        end else if (wr && hit(paddr, `TFIC_OFS_CMP_HIGH)) begin
            cmp_q[15:8] <= pwdata[7:0];
        end else if (wr && hit(paddr, `TFIC_OFS_CMP_LOW)) begin
            cmp_q[7:0]  <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_block_q <= 1'b0;
        end else if (wr && hit(paddr, `TFIC_OFS_CMP_HIGH)) begin
            cmp_block_q <= 1'b1; // [R19]
        end else if (wr && hit(paddr, `TFIC_OFS_CMP_LOW)) begin
            cmp_block_q <= 1'b0; // [R19]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_block_q <= 1'b0;
        end else if (rd && hit(paddr, `TFIC_OFS_CAP_HIGH)) begin
            cap_block_q <= 1'b1; // [R18]
        end else if (rd && hit(paddr, `TFIC_OFS_CAP_LOW)) begin
            cap_block_q <= 1'b0; // [R18]
        end
    end

    // ----------------------------------------------------------------
    // Counter low-byte buffers, one per view
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_hold_q <= 1'b0;
            cnt_buf_q  <= 8'h00;
        end else if (rd && hit(paddr, `TFIC_OFS_CNT_HIGH) && !cnt_hold_q) begin
            cnt_hold_q <= 1'b1; // [R20]
            cnt_buf_q  <= count[7:0];
        end else if (rd && hit(paddr, `TFIC_OFS_CNT_LOW)) begin
            cnt_hold_q <= 1'b0; // [R20]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_hold_q <= 1'b0;
            alt_buf_q  <= 8'h00;
        end else if (rd && hit(paddr, `TFIC_OFS_ALT_HIGH) && !alt_hold_q) begin
            alt_hold_q <= 1'b1; // [R20]
            alt_buf_q  <= count[7:0];
        end else if (rd && hit(paddr, `TFIC_OFS_ALT_LOW)) begin
            alt_hold_q <= 1'b0; // [R20]
        end
    end

    // ----------------------------------------------------------------
    // Status flags and two-step clear
    // ----------------------------------------------------------------
    tfic_flags u_flags (
        .pclk        (pclk),
        .presetn     (presetn),
        .ev          (ev.flags),
        .status_rd   (rd && hit(paddr, `TFIC_OFS_STATUS)),
        .cap_lo_rd   (rd && hit(paddr, `TFIC_OFS_CAP_LOW)),
        .cmp_lo_wr   (wr && hit(paddr, `TFIC_OFS_CMP_LOW)),
        .cnt_lo_rd   (rd && hit(paddr, `TFIC_OFS_CNT_LOW)),
        .cap_flag    (cap_f_q),
        .cmp_flag    (cmp_f_q),
        .roll_flag   (roll_f_q)
    );

    // ----------------------------------------------------------------
    // Compare output latch and interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0; // [R1]
        end else if (cmp_ev) begin
            out_q <= control_q[`TFIC_BIT_LEVEL_SEL]; // [R6]
        end
    end

    // Mirror of the flag block's clear arming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_arm_q <= 3'b000;
        end else if (rd && hit(paddr, `TFIC_OFS_STATUS)) begin
            clr_arm_q <= {cap_f_q, cmp_f_q, roll_f_q}; // [R7]
        end
    end

    assign ctl_nx     = (wr && hit(paddr, `TFIC_OFS_CONTROL)) ? (pwdata[7:0] & 8'he3) : control_q;

    // Next flag values gated by their enables; an event beats an armed clear
    assign arm_cap_q  = ctl_nx[`TFIC_BIT_CAP_IE] && !stop_exit_reset
                        && (cap_ev
                        || (cap_f_q && !(rd && hit(paddr, `TFIC_OFS_CAP_LOW) && clr_arm_q[2]))); // [R2]
    assign arm_cmp_q  = ctl_nx[`TFIC_BIT_CMP_IE]
                        && (cmp_ev
                        || (cmp_f_q && !(wr && hit(paddr, `TFIC_OFS_CMP_LOW) && clr_arm_q[1]))); // [R3]
    assign arm_roll_q = ctl_nx[`TFIC_BIT_ROLL_IE]
                        && (roll
                        || (roll_f_q && !(rd && hit(paddr, `TFIC_OFS_CNT_LOW) && clr_arm_q[0]))); // [R4]

    // Registered so the request rises with its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= arm_cap_q || arm_cmp_q || arm_roll_q; // [R12] [R21]
        end
    end

    // ----------------------------------------------------------------
    // APB read data and answer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            if (rd) begin
                unique case (paddr)
                    `TFIC_OFS_CONTROL:  prdata_q[7:0] <= control_q;
                    `TFIC_OFS_STATUS:   prdata_q[7:0] <= {cap_f_q, cmp_f_q, roll_f_q, 5'h00};
                    `TFIC_OFS_CNT_HIGH: prdata_q[7:0] <= count[15:8];
                    `TFIC_OFS_CNT_LOW:  prdata_q[7:0] <= cnt_hold_q ? cnt_buf_q : count[7:0]; // [R20]
                    `TFIC_OFS_ALT_HIGH: prdata_q[7:0] <= count[15:8]; // [R8]
                    `TFIC_OFS_ALT_LOW:  prdata_q[7:0] <= alt_hold_q ? alt_buf_q : count[7:0]; // [R8]
                    `TFIC_OFS_CAP_HIGH: prdata_q[7:0] <= cap_q[15:8];
                    `TFIC_OFS_CAP_LOW:  prdata_q[7:0] <= cap_q[7:0];
                    `TFIC_OFS_CMP_HIGH: prdata_q[7:0] <= cmp_q[15:8];
                    `TFIC_OFS_CMP_LOW:  prdata_q[7:0] <= cmp_q[7:0];
                    default:            pslverr_q     <= 1'b1;
                endcase
            end else if (wr) begin
                pslverr_q <= !(hit(paddr, `TFIC_OFS_CONTROL) || hit(paddr, `TFIC_OFS_CMP_HIGH)
                               || hit(paddr, `TFIC_OFS_CMP_LOW));
            end
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign compare_out_pin = out_q;
    assign timer_irq       = irq_q;
endmodule // tfic_top
`default_nettype wire

//--- design/tfic_defs.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TFIC_DEFS_SVH
`define TFIC_DEFS_SVH

`define TFIC_OFS_CONTROL       12'h000
`define TFIC_OFS_STATUS        12'h004
`define TFIC_OFS_CNT_HIGH      12'h008
`define TFIC_OFS_CNT_LOW       12'h00c
`define TFIC_OFS_ALT_HIGH      12'h010
`define TFIC_OFS_ALT_LOW       12'h014
`define TFIC_OFS_CAP_HIGH      12'h018
`define TFIC_OFS_CAP_LOW       12'h01c
`define TFIC_OFS_CMP_HIGH      12'h020
`define TFIC_OFS_CMP_LOW       12'h024

`define TFIC_BIT_CAP_IE        7
`define TFIC_BIT_CMP_IE        6
`define TFIC_BIT_ROLL_IE       5
`define TFIC_BIT_EDGE_SEL      1
`define TFIC_BIT_LEVEL_SEL     0
`define TFIC_BIT_CAP_FLAG      7
`define TFIC_BIT_CMP_FLAG      6
`define TFIC_BIT_ROLL_FLAG     5

`define TFIC_CONTROL_RESET     8'h00
`define TFIC_COUNTER_RESET     16'hfffc
`define TFIC_CAP_RESET         16'h0000
`define TFIC_CMP_RESET         16'hffff
`define TFIC_ROLL_FROM         16'hffff
`define TFIC_PRESCALE          4

`endif

//--- design/tfic_pkg.sv
// Types shared by the timer control modules
package tfic_pkg;
    typedef enum logic [2:0] {
        TFIC_RUN       = 3'b001,
        TFIC_STOPPED   = 3'b010,
        TFIC_WAKE      = 3'b100
    } tfic_pwr_t;
    typedef logic [15:0] tfic_count_t;
endpackage

//--- design/tfic_ev_if.sv
// Event and count bundle between the timer core and its flag block
`timescale 1ns/1ps
`default_nettype none
interface tfic_ev_if;
    import tfic_pkg::*;
    logic        cap_ev;
    logic        cmp_ev;
    logic        roll_ev;
    logic        drop_cap;
    tfic_count_t count;
    modport core (output cap_ev, output cmp_ev, output roll_ev, output drop_cap, output count);
    modport flags (input cap_ev, input cmp_ev, input roll_ev, input drop_cap, input count);
endinterface
`default_nettype wire

//--- design/tfic_counter.sv
// Prescaled free-running counter with stop-mode freeze and exit handling
`timescale 1ns/1ps
`default_nettype none
`include "tfic_defs.svh"
module tfic_counter
    import tfic_pkg::*;
#(
    parameter int PRESCALE = `TFIC_PRESCALE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stop_mode,
    input  wire logic        stop_exit_reset,
    output logic             tick,
    output tfic_count_t      count,
    output logic             roll
);
    logic [7:0]  pre_q;
    tfic_count_t count_q;

    // ----------------------------------------------------------------
    // Prescaler and counter
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 8'h00;
        end else if (stop_exit_reset) begin
            pre_q <= 8'h00;
        end else if (!stop_mode) begin
            pre_q <= (pre_q == 8'(PRESCALE - 1)) ? 8'h00 : pre_q + 8'h01; // [R17]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `TFIC_COUNTER_RESET;
        end else if (stop_exit_reset) begin
            count_q <= `TFIC_COUNTER_RESET; // [R14]
        end else if (!stop_mode && pre_q == 8'(PRESCALE - 1)) begin
            count_q <= count_q + 16'h0001; // [R13] [R17]
        end
    end

    assign tick  = !stop_mode && !stop_exit_reset && pre_q == 8'(PRESCALE - 1);
    assign count = count_q;
    assign roll  = tick && count_q == `TFIC_ROLL_FROM; // [R11]
endmodule // tfic_counter
`default_nettype wire

//--- design/tfic_flags.sv
// Event flags with status-read arming and register-access clearing
`timescale 1ns/1ps
`default_nettype none
module tfic_flags
    import tfic_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    tfic_ev_if.flags   ev,
    input  wire logic  status_rd,
    input  wire logic  cap_lo_rd,
    input  wire logic  cmp_lo_wr,
    input  wire logic  cnt_lo_rd,
    output logic       cap_flag,
    output logic       cmp_flag,
    output logic       roll_flag
);
    logic cap_q, cmp_q, roll_q;
    logic cap_arm_q, cmp_arm_q, roll_arm_q;

    // ----------------------------------------------------------------
    // Arming: a status read seen with the flag set arms its clear
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_arm_q  <= 1'b0;
            cmp_arm_q  <= 1'b0;
            roll_arm_q <= 1'b0;
        end else if (status_rd) begin
            cap_arm_q  <= cap_q; // [R7]
            cmp_arm_q  <= cmp_q; // [R7]
            roll_arm_q <= roll_q; // [R7]
        end
    end

    // ----------------------------------------------------------------
    // Flags: a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= 1'b0;
        end else if (ev.drop_cap) begin
            cap_q <= 1'b0; // [R16]
        end else if (ev.cap_ev) begin
            cap_q <= 1'b1; // [R9]
        end else if (cap_lo_rd && cap_arm_q) begin
            cap_q <= 1'b0; // [R7] [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= 1'b0;
        end else if (ev.cmp_ev) begin
            cmp_q <= 1'b1; // [R10]
        end else if (cmp_lo_wr && cmp_arm_q) begin
            cmp_q <= 1'b0; // [R7] [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roll_q <= 1'b0;
        end else if (ev.roll_ev) begin
            roll_q <= 1'b1; // [R11]
        end else if (cnt_lo_rd && roll_arm_q) begin
            roll_q <= 1'b0; // [R7] [R8] [R11]
        end
    end

    assign cap_flag  = cap_q;
    assign cmp_flag  = cmp_q;
    assign roll_flag = roll_q;
endmodule // tfic_flags
`default_nettype wire

//--- dv/tfic_pin_model.sv
// Far-side model: signal source driving the capture pin
`timescale 1ns/1ps
`default_nettype none
module tfic_pin_model
    import tfic_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic want,
    output logic      capture_in_pin
);
    // Source changes its level just after a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_in_pin <= 1'b0;
        end else begin
            capture_in_pin <= want;
        end
    end
endmodule // tfic_pin_model
`default_nettype wire

//--- dv/tfic_top_asserts.sv
// Port-level checker for the timer control block
`timescale 1ns/1ps
`default_nettype none
module tfic_top_asserts
    import tfic_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        capture_in_pin,
    input wire logic        compare_out_pin,
    input wire logic        stop_mode,
    input wire logic        stop_exit_reset,
    input wire logic        timer_irq
);
    logic [7:0] ctl_q;
    logic       ctl_rd_q;
    logic       lvl_seen_q;
    wire logic  setup = psel && !penable;
    // Shadow of the control register as written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q      <= 8'h00;
            ctl_rd_q   <= 1'b0;
            lvl_seen_q <= 1'b0;
        end else begin
            ctl_rd_q   <= setup && !pwrite && paddr == 12'h000;
            lvl_seen_q <= lvl_seen_q || ctl_q[0];
            if (setup && pwrite && paddr == 12'h000) begin
                ctl_q <= pwdata[7:0] & 8'he3;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    pready_one_a: assert property (setup_s |=> answer_s) else $error("no single ready pulse after setup");
    unmapped_err_a: assert property (setup_s and paddr > 12'h024 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ro_write_a: assert property (setup_s and pwrite && paddr == 12'h004 |=> pslverr)
        else $error("status write not refused");
    ctl_ok_a: assert property (setup_s and paddr == 12'h000 |=> !pslverr) else $error("control access refused");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
    ctl_read_a: assert property (ctl_rd_q && pready |-> prdata[7:0] == ctl_q) else $error("control readback wrong");
    irq_gate_a: assert property (ctl_q[7:5] == 3'b000 |-> !timer_irq) else $error("request without enable");
    cmp_level_a: assert property ($changed(compare_out_pin) |-> compare_out_pin == ctl_q[0] ||
        compare_out_pin == $past(ctl_q[0])) else $error("compare pin left the chosen level");
    cmp_idle_a: assert property (!lvl_seen_q |-> !compare_out_pin) else $error("compare pin high too early");
    reset_quiet_a: assert property ($rose(presetn) |-> !compare_out_pin && !timer_irq && !pready)
        else $error("outputs active after reset");
endmodule // tfic_top_asserts
bind tfic_top tfic_top_asserts i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in_pin(capture_in_pin), .compare_out_pin(compare_out_pin), .stop_mode(stop_mode),
    .stop_exit_reset(stop_exit_reset), .timer_irq(timer_irq)
);
`default_nettype wire

//--- dv/timer_flag_interrupt_control_bench.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer_flag_interrupt_control_bench
    import tfic_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, want, stop_mode, stop_exit_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        pready, pslverr, err, cap_pin, cmp_pin, timer_irq;
    logic [7:0]  hi;
    tfic_count_t cnt_v, c0;
    int          n_mismatch = 0;
    int          checks = 0;

    always #20 pclk = ~pclk;

    tfic_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_in_pin(cap_pin), .compare_out_pin(cmp_pin), .stop_mode(stop_mode),
        .stop_exit_reset(stop_exit_reset), .timer_irq(timer_irq)
    );
    tfic_pin_model i_pins (.pclk(pclk), .presetn(presetn), .want(want), .capture_in_pin(cap_pin));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic st(input logic [7:0] e);
        rd(12'h004);
        check(rv, {24'h0, e});
    endtask
    task automatic read_cnt;
        rd(12'h008);
        hi = rv[7:0];
        rd(12'h00c);
        cnt_v = {hi, rv[7:0]};
    endtask
    task automatic pin(input logic v);
        @(posedge pclk);
        want <= v;
        repeat (40) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check(cmp_pin, 1'b0);
        read_cnt;
        check({hi, rv[7:2]}, 14'h3fff);
        rd(12'h000);
        check(rv, 32'h0);
        rd(12'h020);
        check(rv, 32'hff);
    endtask
    task automatic t_errors;
        rd(12'h028);
        check({err, rv[7:0]}, 9'h100);
        wr(12'h004, 8'hff);
        check(err, 1'b1);
        wr(12'h000, 8'hff);
        rd(12'h000);
        check(rv, 32'he3);
        wr(12'h000, 8'h00);
    endtask
    task automatic t_roll;
        rd(12'h00c);
        st(8'h60);
        rd(12'h010);
        rd(12'h014);
        st(8'h60);
        wr(12'h000, 8'h20);
        check(timer_irq, 1'b1);
        wr(12'h000, 8'h00);
        check(timer_irq, 1'b0);
        rd(12'h00c);
        st(8'h40);
    endtask
    task automatic t_compare;
        wr(12'h000, 8'h41);
        read_cnt;
        cnt_v = cnt_v + 16'd40;
        wr(12'h024, cnt_v[7:0]);
        wr(12'h020, cnt_v[15:8]);
        repeat (200) @(posedge pclk);
        st(8'h00);
        check(cmp_pin, 1'b0);
        read_cnt;
        cnt_v = cnt_v + 16'd16;
        wr(12'h020, cnt_v[15:8]);
        wr(12'h024, cnt_v[7:0]);
        repeat (100) @(posedge pclk);
        check({cmp_pin, timer_irq}, 2'b11);
        st(8'h40);
        wr(12'h024, cnt_v[7:0]);
        st(8'h00);
    endtask
    task automatic t_capture;
        wr(12'h000, 8'h82);
        read_cnt;
        c0 = cnt_v;
        pin(1'b1);
        st(8'h80);
        check(timer_irq, 1'b1);
        rd(12'h018);
        hi = rv[7:0];
        pin(1'b0);
        pin(1'b1);
        rd(12'h01c);
        cnt_v = {hi, rv[7:0]} - c0;
        check(cnt_v < 16'd8, 1'b1);
        rd(12'h004);
        rd(12'h01c);
        st(8'h00);
        pin(1'b0);
        st(8'h00);
        wr(12'h000, 8'h80);
        pin(1'b1);
        st(8'h00);
        pin(1'b0);
        st(8'h80);
        rd(12'h01c);
    endtask
    task automatic t_stop;
        pin(1'b1);
        @(posedge pclk);
        stop_mode <= 1'b1;
        read_cnt;
        c0 = cnt_v;
        pin(1'b0);
        st(8'h00);
        read_cnt;
        check(cnt_v, c0);
        @(posedge pclk);
        stop_mode <= 1'b0;
        repeat (8) @(posedge pclk);
        st(8'h80);
        read_cnt;
        cnt_v = cnt_v - c0;
        check(cnt_v < 16'd8, 1'b1);
        rd(12'h01c);
        pin(1'b1);
        @(posedge pclk);
        stop_mode <= 1'b1;
        pin(1'b0);
        @(posedge pclk);
        stop_exit_reset <= 1'b1;
        stop_mode <= 1'b0;
        @(posedge pclk);
        stop_exit_reset <= 1'b0;
        st(8'h00);
        read_cnt;
        check({hi, rv[7:2]}, 14'h3fff);
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, want, stop_mode, stop_exit_reset} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_errors;
        t_roll;
        t_compare;
        t_capture;
        t_stop;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end
endmodule // timer_flag_interrupt_control_bench
`default_nettype wire
